//--- rtl/dmag_pkg.sv
// Package with constants, types and helpers of the data memory address generator.
//
// Functional notes
// [R1] Access bank is low 128 bytes of bank 0 then upper 128 bytes of bank 15.
// [R2] Access bit zero selects the access bank, one selects the bank select register.
// [R3] In access mode the last low location is followed by the first high location.
// [R4] Sixteen banks; bank select low nibble gives address bits 11 to 8.
// [R5] Bank select upper nibble reads zero and writes to it are dropped.
// [R6] Unimplemented bank: reads give zero, writes ignored, core flags unaffected here.
// [R7] Each bank holds 256 byte locations, offsets 00h to FFh.
// [R8] Full address move uses 12-bit addresses from the instruction, ignores bank select.
// [R9] Load bank literal writes a literal bank number into bank select.
// [R10] Access to an indirect location goes to the address held in its pointer.
// [R11] Indirect read whose pointer names an indirect location returns 00h.
// [R12] Indirect write whose pointer names an indirect location does nothing; the code drops the write but still applies the pointer's automatic update.
// [R13] Each pointer holds a full 12-bit data address.
// [R14] Indirect locations have no storage; they redirect through their pointer.
// [R15] Five locations per pointer: none, post-dec, post-inc, pre-inc, plus signed offset.
// [R16] Pointer increment and decrement act on all 12 bits with carry.
// [R17] Automatic pointer updates never change arithmetic status flags.
// [R18] Indirect write to a pointer's own byte beats its automatic update.
// [R19] Access mode offsets below 80h map to bank 0, others to bank 15.
package dmag_pkg;

   // ---------------------------------------------
   // Register map on the bus
   // ---------------------------------------------
   localparam logic [4:0] REG_BANK = 5'h00;
   localparam logic [4:0] REG_PTR0 = 5'h04;
   localparam logic [4:0] REG_PTR1 = 5'h08;
   localparam logic [4:0] REG_PTR2 = 5'h0C;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam int ST_UNIMPL_BIT = 16;
   localparam int ST_SELF_BIT = 17;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [11:0] PTR_RESET = 12'h000;

   // ---------------------------------------------
   // Data space layout
   // ---------------------------------------------
   localparam int NUM_PTR = 3;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [11:0] VIRT_BASE = 12'hFE0;
   localparam logic [2:0] PTR_HI_SLOT = 3'h5;
   localparam logic [2:0] PTR_LO_SLOT = 3'h6;

   typedef enum logic [2:0] {
      PM_NONE = 3'h0,
      PM_POSTDEC = 3'h1,
      PM_POSTINC = 3'h2,
      PM_PREINC = 3'h3,
      PM_PLUSW = 3'h4
   } dmag_mode_e;

   typedef enum logic {
      AV_IDLE = 1'b0,
      AV_ACK = 1'b1
   } dmag_av_e;

   // ---------------------------------------------
   // Address helpers
   // ---------------------------------------------
   // Pointer n owns slots VIRT_BASE + 8n + 0..6.
   function automatic logic in_ptr_block(input logic [11:0] a);
      return (a[11:5] == VIRT_BASE[11:5]) && (a[4:3] != 2'h3);
   endfunction : in_ptr_block

   function automatic logic is_virt(input logic [11:0] a);
      return in_ptr_block(a) && (a[2:0] <= 3'h4);
   endfunction : is_virt

   function automatic logic is_ptr_byte(input logic [11:0] a);
      return in_ptr_block(a) && ((a[2:0] == PTR_HI_SLOT) || (a[2:0] == PTR_LO_SLOT));
   endfunction : is_ptr_byte

   function automatic logic [11:0] eff_addr(input logic [11:0] p, input dmag_mode_e m, input logic [7:0] w);
      case (m)
         PM_PREINC: return p + 12'h001;
         PM_PLUSW: return p + {{4{w[7]}}, w};
         default: return p;
      endcase
   endfunction : eff_addr

   function automatic logic [11:0] next_ptr(input logic [11:0] p, input dmag_mode_e m);
      case (m)
         PM_POSTDEC: return p - 12'h001;
         PM_POSTINC, PM_PREINC: return p + 12'h001;
         default: return p;
      endcase
   endfunction : next_ptr

endpackage : dmag_pkg

//--- rtl/dmag_ptr_if.sv
// Interface between the address generator and its pointer file.
`timescale 1ns/10ps
`default_nettype none
interface dmag_ptr_if;
   import dmag_pkg::*;
   logic upd;
   logic [1:0] upd_idx;
   dmag_mode_e mode;
   logic bw;
   logic [1:0] bw_idx;
   logic bw_hi;
   logic [7:0] bw_data;
   logic aw;
   logic [1:0] aw_idx;
   logic aw_lo;
   logic aw_hi;
   logic [11:0] aw_data;
   logic [NUM_PTR-1:0][11:0] ptr;
   modport ctl (output upd, upd_idx, mode, bw, bw_idx, bw_hi, bw_data, aw, aw_idx, aw_lo, aw_hi, aw_data,
      input ptr);
   modport file (input upd, upd_idx, mode, bw, bw_idx, bw_hi, bw_data, aw, aw_idx, aw_lo, aw_hi, aw_data,
      output ptr);
endinterface : dmag_ptr_if
`default_nettype wire

//--- rtl/dmag_bank_map.sv
// Direct address formation from bank select, access bit and full address.
`timescale 1ns/10ps
`default_nettype none
module dmag_bank_map
   import dmag_pkg::*;
(
   input wire logic bank_sel,
   input wire logic [7:0] offset,
   input wire logic [3:0] bank,
   input wire logic full,
   input wire logic [11:0] full_addr,
   output logic [11:0] addr
);
   always_comb begin
      if (full) begin
         addr = full_addr; // [R8]
      end else if (bank_sel) begin
         addr = {bank, offset}; // [R4] [R7]
      end else if (!offset[7]) begin
         addr = {ACCESS_LOW_BANK, offset}; // [R1] [R19]
      end else begin
         addr = {ACCESS_HIGH_BANK, offset}; // [R3] [R19]
      end
   end
endmodule : dmag_bank_map
`default_nettype wire

//--- rtl/dmag_ptr_file.sv
// Three 12-bit pointers with automatic update and byte writes.
`timescale 1ns/10ps
`default_nettype none
module dmag_ptr_file
   import dmag_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   dmag_ptr_if.file pif
);
   typedef struct packed {
      logic [NUM_PTR-1:0][11:0] ptr;
   } dmag_pf_s;

   dmag_pf_s s_q;
   dmag_pf_s s_d;

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < NUM_PTR; i++) begin
         if (pif.aw && pif.aw_idx == 2'(i)) begin
            if (pif.aw_lo) s_d.ptr[i][7:0] = pif.aw_data[7:0];
            if (pif.aw_hi) s_d.ptr[i][11:8] = pif.aw_data[11:8];
         end
         // Status flags live in the core and are never touched from here.
         if (pif.upd && pif.upd_idx == 2'(i) && !(pif.bw && pif.bw_idx == 2'(i))) begin
            s_d.ptr[i] = next_ptr(s_q.ptr[i], pif.mode); // [R15] [R16] [R17]
         end
         if (pif.bw && pif.bw_idx == 2'(i)) begin
            if (pif.bw_hi) s_d.ptr[i][11:8] = pif.bw_data[3:0]; // [R18]
            else s_d.ptr[i][7:0] = pif.bw_data; // [R18]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{ptr: {NUM_PTR{PTR_RESET}}};
      end else begin
         s_q <= s_d;
      end
   end

   assign pif.ptr = s_q.ptr; // [R13]
endmodule : dmag_ptr_file
`default_nettype wire

//--- rtl/dmag_top.sv
// Data memory address generator with bank select, access bank and indirect pointers.
`timescale 1ns/10ps
`default_nettype none
module dmag_top
   import dmag_pkg::*;
#(
   parameter logic [15:0] BANK_IMPL = 16'h800F
)
(
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic [4:0] AV_ADDRESS,
   input wire logic AV_READ,
   input wire logic AV_WRITE,
   input wire logic [31:0] AV_WRITEDATA,
   input wire logic [3:0] AV_BYTEENABLE,
   output logic [31:0] AV_READDATA,
   output logic AV_WAITREQUEST,
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic REQ_BANK_SEL,
   input wire logic [7:0] REQ_OFFSET,
   input wire logic REQ_FULL,
   input wire logic [11:0] REQ_FULL_ADDR,
   input wire logic [7:0] REQ_WDATA,
   input wire logic [7:0] WORKING_ACCUMULATOR,
   input wire logic LOAD_BANK_LITERAL,
   input wire logic [7:0] BANK_LITERAL,
   output logic [11:0] MEM_ADDR,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic [7:0] MEM_WDATA,
   input wire logic [7:0] MEM_RDATA,
   output logic RSP_VALID,
   output logic [7:0] RSP_RDATA
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      dmag_av_e av;
      logic waitreq;
      logic [31:0] av_rdata;
      logic [3:0] bank;
      logic [11:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] mem_wdata;
      logic pend;
      logic pend_zero;
      logic pend_use_byte;
      logic [7:0] pend_byte;
      logic rsp_valid;
      logic [7:0] rsp_rdata;
      logic [11:0] last_addr;
      logic last_unimpl;
      logic last_self;
   } dmag_top_s;

   dmag_top_s s_q;
   dmag_top_s s_d;

   dmag_ptr_if pif ();

   logic [11:0] dir_addr;
   logic ind_hit;
   logic [1:0] ind_idx;
   dmag_mode_e ind_mode;
   logic [11:0] ptr_val;
   logic [11:0] eff;
   logic self_hit;
   logic impl;
   logic ok;
   logic pbyte;
   logic [11:0] pbyte_ptr;
   logic av_wr;
   logic av_ptr_sel;

   // ---------------------------------------------
   // Address formation
   // ---------------------------------------------
   dmag_bank_map u_map (
      .bank_sel(REQ_BANK_SEL), // [R2]
      .offset(REQ_OFFSET),
      .bank(s_q.bank),
      .full(REQ_FULL),
      .full_addr(REQ_FULL_ADDR),
      .addr(dir_addr)
   );

   dmag_ptr_file u_ptr (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .pif(pif)
   );

   always_comb begin
      ind_hit = is_virt(dir_addr); // [R10] [R14]
      ind_idx = dir_addr[4:3];
      ind_mode = dmag_mode_e'(dir_addr[2:0]);
      ptr_val = pif.ptr[ind_idx];
      eff = ind_hit ? eff_addr(ptr_val, ind_mode, WORKING_ACCUMULATOR) : dir_addr; // [R15]
      self_hit = ind_hit && is_virt(eff); // [R11] [R12]
      impl = BANK_IMPL[eff[11:8]]; // [R6]
      ok = !self_hit && impl;
      pbyte = is_ptr_byte(eff);
      pbyte_ptr = pif.ptr[eff[4:3]];
   end

   // ---------------------------------------------
   // Pointer file control
   // ---------------------------------------------
   assign av_wr = (s_q.av == AV_ACK) && AV_WRITE;
   assign av_ptr_sel = (AV_ADDRESS == REG_PTR0) || (AV_ADDRESS == REG_PTR1) || (AV_ADDRESS == REG_PTR2);
   assign pif.upd = REQ_VALID && ind_hit; // [R15]
   assign pif.upd_idx = ind_idx;
   assign pif.mode = ind_mode;
   assign pif.bw = REQ_VALID && REQ_WRITE && ok && pbyte; // [R18]
   assign pif.bw_idx = eff[4:3];
   assign pif.bw_hi = (eff[2:0] == PTR_HI_SLOT);
   assign pif.bw_data = REQ_WDATA;
   assign pif.aw = av_wr && av_ptr_sel;
   assign pif.aw_idx = AV_ADDRESS[3:2] - 2'h1;
   assign pif.aw_lo = AV_BYTEENABLE[0];
   assign pif.aw_hi = AV_BYTEENABLE[1];
   assign pif.aw_data = AV_WRITEDATA[11:0];

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.mem_rd = 1'b0;
      s_d.mem_wr = 1'b0;
      s_d.pend = 1'b0;
      s_d.rsp_valid = 1'b0;
      // Bus slave: one wait cycle, then the access completes at the edge that sees waitrequest low.
      unique case (s_q.av)
         AV_IDLE: begin
            if (AV_READ || AV_WRITE) begin
               s_d.av = AV_ACK;
               s_d.waitreq = 1'b0;
               s_d.av_rdata = '0;
               unique case (AV_ADDRESS)
                  REG_BANK: s_d.av_rdata[3:0] = s_q.bank; // [R5]
                  REG_PTR0: s_d.av_rdata[11:0] = pif.ptr[0];
                  REG_PTR1: s_d.av_rdata[11:0] = pif.ptr[1];
                  REG_PTR2: s_d.av_rdata[11:0] = pif.ptr[2];
                  REG_STATUS: begin
                     s_d.av_rdata[11:0] = s_q.last_addr;
                     s_d.av_rdata[ST_UNIMPL_BIT] = s_q.last_unimpl;
                     s_d.av_rdata[ST_SELF_BIT] = s_q.last_self;
                  end
                  default: s_d.av_rdata = '0;
               endcase
            end
         end
         AV_ACK: begin
            s_d.av = AV_IDLE;
            s_d.waitreq = 1'b1;
         end
      endcase
      if (av_wr && AV_ADDRESS == REG_BANK && AV_BYTEENABLE[0]) begin
         s_d.bank = AV_WRITEDATA[3:0]; // [R5]
      end
      if (LOAD_BANK_LITERAL) begin
         s_d.bank = BANK_LITERAL[3:0]; // [R9] [R5]
      end
      if (REQ_VALID) begin
         s_d.mem_addr = eff;
         s_d.mem_wdata = REQ_WDATA;
         s_d.mem_rd = !REQ_WRITE && ok && !pbyte;
         s_d.mem_wr = REQ_WRITE && ok && !pbyte; // [R6] [R12]
         s_d.pend = !REQ_WRITE;
         s_d.pend_zero = !ok; // [R6] [R11]
         s_d.pend_use_byte = pbyte;
         s_d.pend_byte = (eff[2:0] == PTR_HI_SLOT) ? {4'h0, pbyte_ptr[11:8]} : pbyte_ptr[7:0];
         s_d.last_addr = eff;
         s_d.last_unimpl = !impl;
         s_d.last_self = self_hit;
      end
      if (s_q.pend) begin
         s_d.rsp_valid = 1'b1;
         if (s_q.pend_zero) s_d.rsp_rdata = 8'h00; // [R11]
         else if (s_q.pend_use_byte) s_d.rsp_rdata = s_q.pend_byte;
         else s_d.rsp_rdata = MEM_RDATA;
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q <= '{av: AV_IDLE, waitreq: 1'b1, bank: BANK_RESET, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign AV_READDATA = s_q.av_rdata;
   assign AV_WAITREQUEST = s_q.waitreq;
   assign MEM_ADDR = s_q.mem_addr;
   assign MEM_RD = s_q.mem_rd;
   assign MEM_WR = s_q.mem_wr;
   assign MEM_WDATA = s_q.mem_wdata;
   assign RSP_VALID = s_q.rsp_valid;
   assign RSP_RDATA = s_q.rsp_rdata;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);

   property p_access_low;
      REQ_VALID && !REQ_FULL && !REQ_BANK_SEL && !REQ_OFFSET[7] |-> dir_addr == {4'h0, REQ_OFFSET};
   endproperty
   a_access_low: assert property (p_access_low) else $error("Access low offset not in bank 0."); // [R19]

   property p_access_high;
      REQ_VALID && !REQ_FULL && !REQ_BANK_SEL && REQ_OFFSET[7] |-> dir_addr == {4'hF, REQ_OFFSET};
   endproperty
   a_access_high: assert property (p_access_high) else $error("Access high offset not in bank 15."); // [R3]

   property p_banked;
      REQ_VALID && !REQ_FULL && REQ_BANK_SEL |-> dir_addr[11:8] == s_q.bank && dir_addr[7:0] == REQ_OFFSET;
   endproperty
   a_banked: assert property (p_banked) else $error("Banked address does not use bank select."); // [R4]

   property p_full;
      REQ_VALID && REQ_FULL && !is_virt(REQ_FULL_ADDR) |=> MEM_ADDR == $past(REQ_FULL_ADDR);
   endproperty
   a_full: assert property (p_full) else $error("Full address move did not use its address."); // [R8]

   property p_bank_load;
      LOAD_BANK_LITERAL ##1 !LOAD_BANK_LITERAL[*2] |-> s_q.bank == $past(BANK_LITERAL[3:0], 2);
   endproperty
   a_bank_load: assert property (p_bank_load) else $error("Bank literal not loaded."); // [R9]

   property p_bank_hi_zero;
      s_q.av == AV_ACK && AV_READ && AV_ADDRESS == REG_BANK |-> AV_READDATA[31:4] == 28'h0000000;
   endproperty
   a_bank_hi_zero: assert property (p_bank_hi_zero) else $error("Bank select upper bits not zero."); // [R5]

   property p_unimpl;
      REQ_VALID && !REQ_WRITE && !impl |=> !MEM_RD ##1 RSP_VALID && RSP_RDATA == 8'h00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("Unimplemented bank read not zero."); // [R6]

   property p_self_read;
      REQ_VALID && !REQ_WRITE && self_hit |-> ##2 RSP_VALID && RSP_RDATA == 8'h00;
   endproperty
   a_self_read: assert property (p_self_read) else $error("Self pointing read not 00h."); // [R11]

   property p_self_write;
      REQ_VALID && REQ_WRITE && (self_hit || !impl) |=> !MEM_WR;
   endproperty
   a_self_write: assert property (p_self_write) else $error("Suppressed write reached memory."); // [R12]

   property p_redirect;
      REQ_VALID && ind_hit && ind_mode == PM_NONE |-> eff == ptr_val;
   endproperty
   a_redirect: assert property (p_redirect) else $error("Indirect access not redirected."); // [R10]

   property p_postinc0;
      REQ_VALID && ind_hit && ind_idx == 2'h0 && ind_mode == PM_POSTINC && !pif.bw && !pif.aw
         |=> pif.ptr[0] == $past(pif.ptr[0]) + 12'h001;
   endproperty
   a_postinc0: assert property (p_postinc0) else $error("Pointer 0 post increment wrong."); // [R16]

   property p_plusw;
      REQ_VALID && ind_hit && ind_mode == PM_PLUSW && !pif.bw && !pif.aw
         |-> eff == ptr_val + {{4{WORKING_ACCUMULATOR[7]}}, WORKING_ACCUMULATOR} ##1 pif.ptr == $past(pif.ptr);
   endproperty
   a_plusw: assert property (p_plusw) else $error("Offset access wrong or pointer moved."); // [R15]

   property p_wr_dominates;
      pif.bw && pif.upd && pif.bw_idx == pif.upd_idx && !pif.bw_hi && !pif.aw
         |=> pif.ptr[$past(pif.bw_idx)][7:0] == $past(pif.bw_data);
   endproperty
   a_wr_dominates: assert property (p_wr_dominates) else $error("Pointer write lost to update."); // [R18]

   property p_av_ack;
      s_q.av == AV_IDLE && (AV_READ || AV_WRITE) |=> !AV_WAITREQUEST ##1 AV_WAITREQUEST;
   endproperty
   a_av_ack: assert property (p_av_ack) else $error("Bus answer timing wrong.");

   property p_cov_preinc;
      REQ_VALID && ind_hit && ind_mode == PM_PREINC;
   endproperty
   c_cov_preinc: cover property (p_cov_preinc);

   property p_cov_self;
      REQ_VALID && self_hit ##2 RSP_VALID;
   endproperty
   c_cov_self: cover property (p_cov_self);

   property p_cov_dominate;
      pif.bw && pif.upd && pif.bw_idx == pif.upd_idx;
   endproperty
   c_cov_dominate: cover property (p_cov_dominate);

endmodule : dmag_top
`default_nettype wire

//--- verification/dmag_ram_model.sv
// Behavioural data RAM that answers the address generator's memory port.
`timescale 1ns/10ps
`default_nettype none
module dmag_ram_model (
   input wire logic clk,
   input wire logic [11:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [4096];
   logic [7:0] last_q;
   initial begin
      last_q = 8'h00;
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
      end
   end
   // Outside a read the data line shows the inverse of the last value, so stale data never matches.
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
   always @(posedge clk) begin
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
      if (mem_rd) begin
         last_q <= mem[mem_addr];
      end
   end
endmodule : dmag_ram_model
`default_nettype wire

//--- verification/dmag_top_test.sv
// Self-checking testbench of the data memory address generator.
`timescale 1ns/10ps
`default_nettype none
module dmag_top_test
   import dmag_pkg::*;
;
   typedef struct packed {
      logic [7:0] lit; logic a; logic [7:0] off; logic full; logic [11:0] faddr;
      logic wr; logic [7:0] w; logic [11:0] eaddr; logic emem; logic [11:0] eptr;
   } dmag_row_s;
   logic clock, reset_n, av_read, av_write, av_waitrequest, req_valid, req_write, req_bank_sel, req_full;
   logic load_bank_literal, mem_rd, mem_wr, rsp_valid;
   logic [4:0] av_address;
   logic [3:0] av_byteenable;
   logic [31:0] av_writedata, av_readdata;
   logic [11:0] req_full_addr, mem_addr;
   logic [7:0] req_offset, req_wdata, working_accumulator, bank_literal, mem_wdata, mem_rdata, rsp_rdata;
   logic [7:0] shadow [4096];
   dmag_row_s rows [16];
   int n_fail, check_count, cycle_cnt;

   dmag_top #(.BANK_IMPL(16'h800F)) DUT (
      .CLOCK(clock),
      .RESET_N(reset_n),
      .AV_ADDRESS(av_address),
      .AV_READ(av_read),
      .AV_WRITE(av_write),
      .AV_WRITEDATA(av_writedata),
      .AV_BYTEENABLE(av_byteenable),
      .AV_READDATA(av_readdata),
      .AV_WAITREQUEST(av_waitrequest),
      .REQ_VALID(req_valid),
      .REQ_WRITE(req_write),
      .REQ_BANK_SEL(req_bank_sel),
      .REQ_OFFSET(req_offset),
      .REQ_FULL(req_full),
      .REQ_FULL_ADDR(req_full_addr),
      .REQ_WDATA(req_wdata),
      .WORKING_ACCUMULATOR(working_accumulator),
      .LOAD_BANK_LITERAL(load_bank_literal),
      .BANK_LITERAL(bank_literal),
      .MEM_ADDR(mem_addr),
      .MEM_RD(mem_rd),
      .MEM_WR(mem_wr),
      .MEM_WDATA(mem_wdata),
      .MEM_RDATA(mem_rdata),
      .RSP_VALID(rsp_valid),
      .RSP_RDATA(rsp_rdata)
   );

   dmag_ram_model ram (
      .clk(clock),
      .mem_addr(mem_addr),
      .mem_rd(mem_rd),
      .mem_wr(mem_wr),
      .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata)
   );

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
      check_count++;
      if (got !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, got);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
         output logic [31:0] q);
      @(posedge clock);
      av_address <= a;
      av_writedata <= d;
      av_byteenable <= be;
      av_write <= wr;
      av_read <= !wr;
      do @(posedge clock); while (av_waitrequest !== 1'b0);
      q = av_readdata;
      av_write <= 1'b0;
      av_read <= 1'b0;
   endtask : av_xfer

   task automatic av_chk(input logic [4:0] a, input logic [31:0] e, input string what);
      logic [31:0] q;
      av_xfer(1'b0, a, 32'h0, 4'hF, q);
      check(what, e, q);
   endtask : av_chk

   task automatic run_row(input dmag_row_s r, input logic [7:0] wd, input logic [7:0] ed);
      @(posedge clock);
      load_bank_literal <= 1'b1;
      bank_literal <= r.lit;
      @(posedge clock);
      load_bank_literal <= 1'b0;
      req_valid <= 1'b1;
      req_write <= r.wr;
      req_bank_sel <= r.a;
      req_offset <= r.off;
      req_full <= r.full;
      req_full_addr <= r.faddr;
      req_wdata <= wd;
      working_accumulator <= r.w;
      @(posedge clock);
      req_valid <= 1'b0;
      #1;
      check("mem_addr", 32'(r.eaddr), 32'(mem_addr));
      check("mem_rd", 32'(r.emem & !r.wr), 32'(mem_rd));
      check("mem_wr", 32'(r.emem & r.wr), 32'(mem_wr));
      if (r.emem && r.wr) check("mem_wdata", 32'(wd), 32'(mem_wdata));
      @(posedge clock);
      #1;
      check("rsp_valid", 32'(!r.wr), 32'(rsp_valid));
      if (!r.wr) check("rsp_rdata", 32'(ed), 32'(rsp_rdata));
      av_chk(REG_BANK, 32'(r.lit[3:0]), "bank");
      av_chk(REG_PTR0, 32'(r.eptr), "ptr0");
   endtask : run_row

   // ---------------------------------------------
   // Clock, timeout and stimulus
   // ---------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial begin
      cycle_cnt = 0;
      forever begin
         @(posedge clock);
         cycle_cnt++;
         if (cycle_cnt == 4000) begin
            n_fail++;
            test_done();
         end
      end
   end

   initial begin
      logic [7:0] ed;
      logic [31:0] q;
      {reset_n, av_read, av_write, req_valid, req_write, req_bank_sel, req_full, load_bank_literal} = '0;
      {av_address, av_byteenable, av_writedata, req_full_addr} = '0;
      {req_offset, req_wdata, working_accumulator, bank_literal} = '0;
      n_fail = 0;
      check_count = 0;
      for (int i = 0; i < 4096; i++) begin
         shadow[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
      end
      rows = '{
         '{8'h00, 1'b0, 8'h7F, 1'b0, 12'h000, 1'b0, 8'h00, 12'h07F, 1'b1, 12'h1FF},
         '{8'h00, 1'b0, 8'h80, 1'b0, 12'h000, 1'b0, 8'h00, 12'hF80, 1'b1, 12'h1FF},
         '{8'hF2, 1'b1, 8'h34, 1'b0, 12'h000, 1'b0, 8'h00, 12'h234, 1'b1, 12'h1FF},
         '{8'h03, 1'b1, 8'hFF, 1'b0, 12'h000, 1'b1, 8'h00, 12'h3FF, 1'b1, 12'h1FF},
         '{8'h05, 1'b1, 8'h10, 1'b0, 12'h000, 1'b0, 8'h00, 12'h510, 1'b0, 12'h1FF},
         '{8'h05, 1'b1, 8'h10, 1'b0, 12'h000, 1'b1, 8'h00, 12'h510, 1'b0, 12'h1FF},
         '{8'h05, 1'b1, 8'h00, 1'b1, 12'h1AB, 1'b0, 8'h00, 12'h1AB, 1'b1, 12'h1FF},
         '{8'h05, 1'b0, 8'h20, 1'b0, 12'h000, 1'b1, 8'h00, 12'h020, 1'b1, 12'h1FF},
         '{8'h00, 1'b0, 8'hE2, 1'b0, 12'h000, 1'b0, 8'h00, 12'h1FF, 1'b1, 12'h200},
         '{8'h00, 1'b0, 8'hE1, 1'b0, 12'h000, 1'b0, 8'h00, 12'h200, 1'b1, 12'h1FF},
         '{8'h00, 1'b0, 8'hE3, 1'b0, 12'h000, 1'b1, 8'h00, 12'h200, 1'b1, 12'h200},
         '{8'h00, 1'b0, 8'hE4, 1'b0, 12'h000, 1'b0, 8'hF0, 12'h1F0, 1'b1, 12'h200},
         '{8'h00, 1'b0, 8'hE0, 1'b0, 12'h000, 1'b0, 8'h00, 12'h200, 1'b1, 12'h200},
         '{8'h0F, 1'b1, 8'hE2, 1'b0, 12'h000, 1'b0, 8'h00, 12'h200, 1'b1, 12'h201},
         '{8'h00, 1'b0, 8'hE8, 1'b0, 12'h000, 1'b0, 8'h00, 12'hFE0, 1'b0, 12'h201},
         '{8'h00, 1'b0, 8'hE8, 1'b0, 12'h000, 1'b1, 8'h00, 12'hFE0, 1'b0, 12'h201}
      };
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      av_chk(REG_BANK, 32'h0, "bank_reset");
      av_chk(REG_PTR2, 32'h0, "ptr2_reset");
      av_chk(REG_STATUS, 32'h0, "status_reset");
      av_xfer(1'b1, 5'h14, 32'hFFFFFFFF, 4'hF, q);
      av_chk(5'h14, 32'h0, "unmapped");
      av_xfer(1'b1, REG_BANK, 32'hFFFFFFF3, 4'hF, q);
      av_chk(REG_BANK, 32'h3, "bank_upper");
      av_xfer(1'b1, REG_PTR0, 32'hFFFFF1FF, 4'h3, q);
      av_xfer(1'b1, REG_PTR1, 32'h00000FE0, 4'h1, q);
      av_chk(REG_PTR1, 32'h0E0, "ptr1_low_lane");
      av_xfer(1'b1, REG_PTR1, 32'h00000F00, 4'h2, q);
      av_chk(REG_PTR1, 32'hFE0, "ptr1_high_lane");
      av_chk(REG_PTR0, 32'h1FF, "ptr0_full");
      for (int i = 0; i < 16; i++) begin
         ed = (rows[i].emem && !rows[i].wr) ? shadow[rows[i].eaddr] : 8'h00;
         run_row(rows[i], 8'h40 + 8'(i), ed);
         if (rows[i].emem && rows[i].wr) begin
            shadow[rows[i].eaddr] = 8'h40 + 8'(i);
         end
      end
      av_chk(REG_STATUS, 32'h00020FE0, "status_self");
      av_xfer(1'b1, REG_PTR0, 32'h00000FE6, 4'h3, q);
      run_row('{8'h00, 1'b0, 8'hE2, 1'b0, 12'h000, 1'b1, 8'h00, 12'hFE6, 1'b0, 12'hF55}, 8'h55, 8'h00);
      run_row('{8'h00, 1'b0, 8'hE6, 1'b0, 12'h000, 1'b0, 8'h00, 12'hFE6, 1'b0, 12'hF55}, 8'h00, 8'h55);
      // A high byte write keeps only the low nibble; reading it back gives that nibble.
      run_row('{8'h00, 1'b0, 8'hE5, 1'b0, 12'h000, 1'b1, 8'h00, 12'hFE5, 1'b0, 12'h755}, 8'hA7, 8'h00);
      run_row('{8'h00, 1'b0, 8'hE5, 1'b0, 12'h000, 1'b0, 8'h00, 12'hFE5, 1'b0, 12'h755}, 8'h00, 8'h07);
      run_row('{8'h00, 1'b0, 8'hF3, 1'b0, 12'h000, 1'b0, 8'h00, 12'h001, 1'b1, 12'h755}, 8'h00, 8'h01);
      av_chk(REG_PTR2, 32'h001, "ptr2_preinc");
      @(posedge clock);
      reset_n <= 1'b0;
      @(posedge clock);
      #1;
      check("wait_in_reset", 32'h1, 32'(av_waitrequest));
      check("addr_in_reset", 32'h0, 32'(mem_addr));
      @(posedge clock);
      reset_n <= 1'b1;
      av_chk(REG_BANK, 32'h0, "bank_after_reset");
      av_chk(REG_PTR0, 32'h0, "ptr0_after_reset");
      test_done();
   end
endmodule : dmag_top_test
`default_nettype wire
